// File: hw/byte_alu_map.svh
// offsets, widths, opcode codes and reset values for the byte alu
`ifndef BYTE_ALU_MAP_SVH
`define BYTE_ALU_MAP_SVH
`define ALU_OP_NONE      3'h0
`define ALU_OP_ADD_LIT   3'h1
`define ALU_OP_ADD_REG   3'h2
`define ALU_OP_AND_LIT   3'h3
`define ALU_OP_AND_REG   3'h4
`define ALU_OP_BIT_ZERO  3'h5
`define ALU_OP_BIT_ONE   3'h6
`define ALU_OP_SKIP_ZERO 3'h7
`define ALU_ACC_RESET    8'h00
`define ALU_ADDR_MAX     7'h7F
`define ALU_CARRY_BIT    8
`define ALU_NIBBLE_BIT   4
`endif

// File: hw/byte_alu_pkg.sv
// types shared by the byte alu modules
package byte_alu_pkg;
	typedef enum logic [2:0] {
		OP_NONE      = 3'h0,
		OP_ADD_LIT   = 3'h1,
		OP_ADD_REG   = 3'h2,
		OP_AND_LIT   = 3'h3,
		OP_AND_REG   = 3'h4,
		OP_BIT_ZERO  = 3'h5,
		OP_BIT_ONE   = 3'h6,
		OP_SKIP_ZERO = 3'h7
	} alu_op_t;
	typedef enum logic [1:0] {
		ST_RUN  = 2'h1,
		ST_SKIP = 2'h2
	} seq_state_t;
endpackage

// File: hw/alu_result_if.sv
// carrier between the byte alu core and its arithmetic unit
interface alu_result_if;
	logic [7:0] lhs;
	logic [7:0] rhs;
	logic       use_and;
	logic [7:0] result;
	logic       carry;
	logic       nibble;
	logic       zero;
	modport core (output lhs, output rhs, output use_and,
		input result, input carry, input nibble, input zero);
	modport unit (input lhs, input rhs, input use_and,
		output result, output carry, output nibble, output zero);
endinterface

// File: hw/byte_alu_unit.sv
// combinational add / and unit with flag generation
`include "byte_alu_map.svh"
module byte_alu_unit (
	alu_result_if.unit io
);
	logic [8:0] sum;
	logic [4:0] low_sum;

	always_comb begin
		sum     = {1'b0, io.lhs} + {1'b0, io.rhs};
		low_sum = {1'b0, io.lhs[3:0]} + {1'b0, io.rhs[3:0]};
		if (io.use_and) begin
			io.result = io.lhs & io.rhs;
		end else begin
			io.result = sum[7:0];
		end
		io.carry  = sum[`ALU_CARRY_BIT];
		io.nibble = low_sum[`ALU_NIBBLE_BIT];
		io.zero   = (io.result == 8'h00);
	end
endmodule

// File: hw/byte_alu.sv
// byte alu executing add, and, bit write and skip-on-clear instructions
// Summary of operation
// - add literal 0..255 to accumulator, result to accumulator, update carry, nibble, zero.
// - add file register 0..127 to accumulator, update carry, nibble and zero.
// - target select 0 writes accumulator, 1 writes the addressed file register.
// - and literal with accumulator into accumulator, only zero flag changes.
// - and file register with accumulator into selected target, only zero flag.
// - bit zero write clears chosen bit 0..7 of register, flags kept.
// - bit one write sets chosen bit 0..7 of register, flags kept.
// - skip test: bit one runs next; bit zero discards next, runs a nop.
`include "byte_alu_map.svh"
module byte_alu (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       issue,
	input  wire logic [2:0] opcode,
	input  wire logic [7:0] literal,
	input  wire logic [6:0] file_addr,
	input  wire logic [2:0] bit_pos,
	input  wire logic       target_sel,
	output logic [6:0]      rf_raddr,
	input  wire logic [7:0] rf_rdata,
	output logic            rf_we,
	output logic [6:0]      rf_waddr,
	output logic [7:0]      rf_wdata,
	output logic [7:0]      accumulator,
	output logic            carry_flag,
	output logic            nibble_overflow_flag,
	output logic            zero_flag,
	output logic            skip_active,
	output logic            retired
);
	byte_alu_pkg::alu_op_t    op;
	byte_alu_pkg::seq_state_t state_q;
	alu_result_if             alu ();
	logic                     exec;
	logic                     is_reg_op;
	logic [7:0]               bit_mask;
	logic [7:0]               acc_q;
	logic                     c_q;
	logic                     dc_q;
	logic                     z_q;
	logic                     we_q;
	logic [6:0]               waddr_q;
	logic [7:0]               wdata_q;
	logic                     retired_q;

	byte_alu_unit u_unit (
		.io (alu.unit)
	);

	assign op        = byte_alu_pkg::alu_op_t'(opcode);
	assign exec      = issue && (state_q == byte_alu_pkg::ST_RUN);
	assign is_reg_op = (op == byte_alu_pkg::OP_ADD_REG) || (op == byte_alu_pkg::OP_AND_REG);
	assign bit_mask  = 8'h01 << bit_pos;
	assign rf_raddr  = file_addr;

	// operand routing
	always_comb begin
		alu.lhs     = acc_q;
		alu.use_and = (op == byte_alu_pkg::OP_AND_LIT) || (op == byte_alu_pkg::OP_AND_REG);
		case (op)
			byte_alu_pkg::OP_ADD_LIT: alu.rhs = literal;
			byte_alu_pkg::OP_AND_LIT: alu.rhs = literal;
			byte_alu_pkg::OP_ADD_REG: alu.rhs = rf_rdata;
			byte_alu_pkg::OP_AND_REG: alu.rhs = rf_rdata;
			default: alu.rhs = 8'h00;
		endcase
	end

	// skip sequencing: discarded slot is a nop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= byte_alu_pkg::ST_RUN;
		end else begin
			case (state_q)
				byte_alu_pkg::ST_RUN: begin
					if (exec && op == byte_alu_pkg::OP_SKIP_ZERO &&
						!rf_rdata[bit_pos]) begin
						state_q <= byte_alu_pkg::ST_SKIP;
					end
				end
				byte_alu_pkg::ST_SKIP: begin
					if (issue) begin
						state_q <= byte_alu_pkg::ST_RUN;
					end
				end
				default: state_q <= byte_alu_pkg::ST_RUN;
			endcase
		end
	end

	// accumulator update
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= `ALU_ACC_RESET;
		end else if (exec) begin
			if (op == byte_alu_pkg::OP_ADD_LIT || op == byte_alu_pkg::OP_AND_LIT) begin
				acc_q <= alu.result;
			end else if (is_reg_op && !target_sel) begin
				acc_q <= alu.result;
			end
		end
	end

	// carry flag: only the add ops touch it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c_q <= 1'b0;
		end else if (exec) begin
			case (op)
				byte_alu_pkg::OP_ADD_LIT,
				byte_alu_pkg::OP_ADD_REG: begin
					c_q <= alu.carry;
				end
				default: begin
					c_q <= c_q;
				end
			endcase
		end
	end

	// nibble flag: only the add ops touch it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dc_q <= 1'b0;
		end else if (exec) begin
			case (op)
				byte_alu_pkg::OP_ADD_LIT,
				byte_alu_pkg::OP_ADD_REG: begin
					dc_q <= alu.nibble;
				end
				default: begin
					dc_q <= dc_q;
				end
			endcase
		end
	end

	// zero flag: add and and ops; bit ops and skip leave it alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			z_q <= 1'b0;
		end else if (exec) begin
			case (op)
				byte_alu_pkg::OP_ADD_LIT,
				byte_alu_pkg::OP_ADD_REG,
				byte_alu_pkg::OP_AND_LIT,
				byte_alu_pkg::OP_AND_REG: begin
					z_q <= alu.zero;
				end
				default: begin
					z_q <= z_q;
				end
			endcase
		end
	end

	// file register write strobe, one cycle per write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			we_q <= 1'b0;
		end else begin
			we_q <= 1'b0;
			if (exec) begin
				case (op)
					byte_alu_pkg::OP_ADD_REG,
					byte_alu_pkg::OP_AND_REG: begin
						we_q <= target_sel;
					end
					byte_alu_pkg::OP_BIT_ZERO,
					byte_alu_pkg::OP_BIT_ONE: begin
						we_q <= 1'b1;
					end
					default: we_q <= 1'b0;
				endcase
			end
		end
	end

	// write address follows the slot address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waddr_q <= 7'h00;
		end else begin
			waddr_q <= file_addr;
		end
	end

	// write data: alu result or read-modify-write of one bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdata_q <= 8'h00;
		end else if (exec) begin
			case (op)
				byte_alu_pkg::OP_ADD_REG,
				byte_alu_pkg::OP_AND_REG: begin
					wdata_q <= alu.result;
				end
				byte_alu_pkg::OP_BIT_ZERO: begin
					wdata_q <= rf_rdata & ~bit_mask;
				end
				byte_alu_pkg::OP_BIT_ONE: begin
					wdata_q <= rf_rdata | bit_mask;
				end
				default: wdata_q <= wdata_q;
			endcase
		end
	end

	// one pulse per consumed instruction slot, including the nop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			retired_q <= 1'b0;
		end else begin
			retired_q <= issue;
		end
	end

	assign accumulator          = acc_q;
	assign carry_flag           = c_q;
	assign nibble_overflow_flag = dc_q;
	assign zero_flag            = z_q;
	assign skip_active          = (state_q == byte_alu_pkg::ST_SKIP);
	assign rf_we                = we_q;
	assign rf_waddr             = waddr_q;
	assign rf_wdata             = wdata_q;
	assign retired              = retired_q;
endmodule

// File: verification/byte_alu_properties.sv
// concurrent checks on the byte alu ports
module byte_alu_properties (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       issue,
	input wire logic [2:0] opcode,
	input wire logic [7:0] literal,
	input wire logic [2:0] bit_pos,
	input wire logic       target_sel,
	input wire logic [7:0] rf_rdata,
	input wire logic       rf_we,
	input wire logic [7:0] rf_wdata,
	input wire logic [7:0] accumulator,
	input wire logic       carry_flag,
	input wire logic       zero_flag,
	input wire logic       skip_active,
	input wire logic       retired
);
	timeunit 1ns;
	timeprecision 1ns;
	logic go;
	assign go = issue && !skip_active;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_skip_taken;
		go && opcode == 3'h7 && !rf_rdata[bit_pos];
	endsequence
	a_retire_pulse: assert property (issue |=> retired) else $error("no retire");
	a_skip_starts: assert property (s_skip_taken |=> skip_active) else $error("no skip");
	a_skip_discards: assert property (s_skip_taken ##1 issue |=> !rf_we && !skip_active
		&& $stable(accumulator)) else $error("skip slot ran");
	a_lit_add: assert property (go && opcode == 3'h1 |=> accumulator ==
		$past(accumulator) + $past(literal)) else $error("add sum");
	a_reg_carry: assert property (go && opcode == 3'h2 |=> carry_flag ==
		(({1'b0, $past(accumulator)} + $past(rf_rdata)) > 9'h0FF)) else $error("carry");
	a_and_zero: assert property (go && opcode == 3'h3 |=> zero_flag ==
		(accumulator == 8'h00) && $stable(carry_flag)) else $error("and flags");
	a_target_reg: assert property (go && opcode == 3'h2 && target_sel |=> rf_we
		&& $stable(accumulator)) else $error("target");
	a_bit_clear: assert property (go && opcode == 3'h5 |=> rf_we && !rf_wdata[$past(bit_pos)]
		&& $stable(zero_flag)) else $error("bit clear");
	a_bit_set: assert property (go && opcode == 3'h6 |=> rf_we && rf_wdata[$past(bit_pos)]
		&& $stable(carry_flag)) else $error("bit set");
endmodule

bind byte_alu byte_alu_properties u_props (.*);

// File: verification/byte_alu_tb_top.sv
// self-checking random bench for the byte alu
module byte_alu_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, issue, target_sel, rf_we, skip_active, retired;
	logic        carry_flag, nibble_overflow_flag, zero_flag;
	logic [2:0]  opcode, bit_pos;
	logic [6:0]  file_addr, rf_waddr;
	logic [7:0]  literal, rf_rdata, rf_wdata, accumulator, ea, r, v;
	logic [8:0]  s;
	logic [4:0]  h;
	logic [31:0] rnd;
	logic [27:0] q[$], exp, seen;
	logic        ec, en, ez, sk, ex, we;
	integer      seed, miscompares, total_checks;

	byte_alu u_dut (.clk(clk), .rst_n(rst_n), .issue(issue), .opcode(opcode),
		.literal(literal), .file_addr(file_addr), .bit_pos(bit_pos),
		.target_sel(target_sel), .rf_raddr(), .rf_rdata(rf_rdata), .rf_we(rf_we),
		.rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .accumulator(accumulator),
		.carry_flag(carry_flag), .nibble_overflow_flag(nibble_overflow_flag),
		.zero_flag(zero_flag), .skip_active(skip_active), .retired(retired));

	task tally_and_finish;
		if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		tally_and_finish;
	end

	// model of the executed slot, noted for the monitor
	initial begin
		seed = 32'hF3CF;
		{miscompares, total_checks, ea, ec, en, ez, sk} = '0;
		{rst_n, issue, opcode, literal, file_addr, bit_pos, target_sel, rf_rdata} = '0;
		repeat (8) @(posedge clk);
		#1 rst_n = 1;
		repeat (2000) begin
			@(posedge clk);
			rnd = $random(seed);
			#1 {issue, opcode, literal, file_addr, bit_pos, target_sel, rf_rdata} = rnd[30:0];
			if (issue) begin
				ex = !sk;
				sk = 0;
				r = (opcode == 3'h1 || opcode == 3'h3) ? literal : rf_rdata;
				s = {1'b0, ea} + {1'b0, r};
				h = {1'b0, ea[3:0]} + {1'b0, r[3:0]};
				v = rf_rdata;
				if (ex) case (opcode)
					3'h1, 3'h2: begin
						v = s[7:0];
						{ec, en, ez} = {s[8], h[4], v == 8'h00};
					end
					3'h3, 3'h4: begin
						v = ea & r;
						ez = v == 8'h00;
					end
					3'h5: v[bit_pos] = 1'b0;
					3'h6: v[bit_pos] = 1'b1;
					3'h7: sk = !rf_rdata[bit_pos];
					default: ;
				endcase
				we = ex && (opcode inside {3'h5, 3'h6} || (opcode inside {3'h2, 3'h4} && target_sel));
				if (ex && opcode inside {[3'h1:3'h4]} && !we) ea = v;
				q.push_back({ea, ec, en, ez, we, sk, we ? file_addr : 7'h00, we ? v : 8'h00});
			end
		end
		@(posedge clk);
		#1 issue = 0;
		repeat (3) @(posedge clk);
		if (q.size() != 0) miscompares++;
		tally_and_finish;
	end

	always @(posedge clk) begin
		#2;
		if (retired === 1'b1) begin
			exp = q.pop_front();
			seen = {accumulator, carry_flag, nibble_overflow_flag, zero_flag, rf_we, skip_active,
				rf_we ? rf_waddr : 7'h00, rf_we ? rf_wdata : 8'h00};
			total_checks++;
			if (seen !== exp) begin
				miscompares++;
				$display("MISMATCH result exp %h seen %h", exp, seen);
			end
		end
	end
endmodule
